// *** logic/brd_pkg.sv ***
// Constants for the board reset distribution block.
// Assumes a single 25 MHz board clock and an AXI4-Lite register port.
`default_nettype none
package brd_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  // Register byte addresses.
  localparam logic [11:0] CTRL_ADDR     = 12'h000;
  localparam logic [11:0] CAUSE_ADDR    = 12'h004;
  localparam logic [11:0] LEVEL_ADDR    = 12'h008;
  // Control register fields and reset value.
  localparam int          CTRL_WD_EN    = 0;
  localparam int          CTRL_VME_EN   = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h3;
  // Source positions in the synchronised source vector.
  localparam int          SRC_SWITCH    = 0;
  localparam int          SRC_WDOG      = 1;
  localparam int          SRC_ALT       = 2;
  localparam int          SRC_ISAIO     = 3;
  localparam int          SRC_VMEIN     = 4;
  localparam int          SRC_SYSSW     = 5;
  localparam int          SRC_LOCAL     = 6;
  localparam int          SRC_CSR       = 7;
  localparam int          SRC_SYSCTL    = 8;
  localparam int          NSRC          = 9;
  // Cause register: bit 0 is power-on, bits 1..8 are sources 0..7.
  localparam int          NCAUSE        = 9;
  localparam logic [8:0]  CAUSE_RESET   = 9'h001;
  // Domain positions.
  localparam int          DOM_CPU       = 0;
  localparam int          DOM_HB        = 1;
  localparam int          DOM_ISA       = 2;
  localparam int          DOM_VME       = 3;
  localparam int          NDOM          = 4;
  // Minimum hold of a domain reset after its last request.
  localparam int          CLK_MHZ       = 25;
  localparam int          HOLD_NS       = 1000;
  localparam int          HOLD_CYC      = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0]  HOLD_LOAD     = 6'(HOLD_CYC);
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : brd_pkg
`default_nettype wire

// *** logic/brd_reset_distribution.sv ***
// Board reset distribution: collects reset sources, drives domain resets.
// Assumes reset pins are asynchronous to sys_clk_i; the AXI4-Lite master
// runs on sys_clk_i. resetn_i is the power-on reset.
//
// How it works
// - Switch resets processor, bridge, ISA, VME if controller.
// - Watchdog asserts VMEbus reset when system controller.
// - Alternate request resets ISA, VME if controller.
// - ISA I/O request resets only ISA devices.
// - System software reset drives VME, not processor.
// - Local or CSR reset: processor, bridge, ISA only.
`default_nettype none
module brd_reset_distribution (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        reset_switch_n_i,
  input  wire logic        watchdog_reset_n_i,
  input  wire logic        alternate_reset_request_i,
  input  wire logic        isa_io_reset_request_i,
  input  wire logic        vme_sysreset_n_i,
  input  wire logic        vme_system_sw_reset_i,
  input  wire logic        vme_local_sw_reset_i,
  input  wire logic        vme_csr_reset_i,
  input  wire logic        system_controller_i,
  output logic             processor_unit_reset_n_o,
  output logic             processor_host_bridge_reset_n_o,
  output logic             isa_reset_n_o,
  output logic             vme_sysreset_o,
  output logic             vme_sysreset_oe_o,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  logic [brd_pkg::NSRC-1:0]   raw;
  logic [brd_pkg::NSRC-1:0]   sync1_reg;
  logic [brd_pkg::NSRC-1:0]   src_reg;
  logic [brd_pkg::NSRC-1:0]   src_d_reg;
  logic [brd_pkg::NDOM-1:0]   req;
  logic [brd_pkg::NDOM-1:0]   rst_n_reg;
  logic [5:0]                 cnt_reg [brd_pkg::NDOM];
  logic                       vme_oe_reg;
  logic [1:0]                 ctrl_reg;
  logic [brd_pkg::NCAUSE-1:0] cause_reg;
  logic [brd_pkg::NCAUSE-1:0] cause_set;
  logic [brd_pkg::NCAUSE-1:0] cause_clr;
  logic                       sysctl;
  logic                       por_reg;

  function automatic logic [5:0] hold_next(input logic r, input logic [5:0] c);
    if (r) begin
      return brd_pkg::HOLD_LOAD;
    end else if (c != 6'h00) begin
      return c - 6'h01;
    end
    return 6'h00;
  endfunction : hold_next

  assign raw = {system_controller_i, vme_csr_reset_i, vme_local_sw_reset_i,
                vme_system_sw_reset_i, ~vme_sysreset_n_i,
                isa_io_reset_request_i, alternate_reset_request_i,
                ~watchdog_reset_n_i, ~reset_switch_n_i};

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg <= '0;
      src_reg   <= '0;
      src_d_reg <= '0;
    end else begin
      sync1_reg <= raw;
      src_reg   <= sync1_reg;
      src_d_reg <= src_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Domain request decoding.
  logic sw, wd, alt, isaio, vin, syssw, loc;
  assign sysctl = src_reg[brd_pkg::SRC_SYSCTL] &
                  ctrl_reg[brd_pkg::CTRL_VME_EN];
  assign sw     = src_reg[brd_pkg::SRC_SWITCH];
  assign wd     = src_reg[brd_pkg::SRC_WDOG] & ctrl_reg[brd_pkg::CTRL_WD_EN];
  assign alt    = src_reg[brd_pkg::SRC_ALT];
  assign isaio  = src_reg[brd_pkg::SRC_ISAIO];
  assign vin    = src_reg[brd_pkg::SRC_VMEIN];
  assign syssw  = src_reg[brd_pkg::SRC_SYSSW];
  assign loc    = src_reg[brd_pkg::SRC_LOCAL] | src_reg[brd_pkg::SRC_CSR];

  always_comb begin
    req[brd_pkg::DOM_CPU] = sw | loc;
    req[brd_pkg::DOM_HB]  = sw | loc | vin;
    req[brd_pkg::DOM_ISA] = sw | loc | alt | isaio;
    // The backplane reset is never echoed back, which would latch forever.
    req[brd_pkg::DOM_VME] = sysctl & (sw | wd |
                                      alt | syssw);
  end

  // Each domain stays in reset while asked and for a hold time after.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int d = 0; d < brd_pkg::NDOM; d++) begin
        cnt_reg[d] <= brd_pkg::HOLD_LOAD;
      end
      rst_n_reg  <= '0;
      vme_oe_reg <= 1'b0;
    end else begin
      for (int d = 0; d < brd_pkg::NDOM; d++) begin
        cnt_reg[d]   <= hold_next(req[d], cnt_reg[d]);
        rst_n_reg[d] <= ~(req[d] | (cnt_reg[d] != 6'h00));
      end
      // After power-on the VME hold runs on every board, but the line is driven only if this board is controller.
      vme_oe_reg <= sysctl & (req[brd_pkg::DOM_VME] |
                    (cnt_reg[brd_pkg::DOM_VME] != 6'h00));
    end
  end

  assign processor_unit_reset_n_o        = rst_n_reg[brd_pkg::DOM_CPU];
  assign processor_host_bridge_reset_n_o = rst_n_reg[brd_pkg::DOM_HB];
  assign isa_reset_n_o                   = rst_n_reg[brd_pkg::DOM_ISA];
  assign vme_sysreset_o                  = rst_n_reg[brd_pkg::DOM_VME];
  assign vme_sysreset_oe_o               = vme_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave. Write address and data are taken in either order.
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  // A low ready means its beat is held, so both low with no response pending performs the write.
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= brd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_reg    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg == brd_pkg::CTRL_ADDR ||
                         awaddr_reg == brd_pkg::CAUSE_ADDR ||
                         awaddr_reg == brd_pkg::LEVEL_ADDR) ?
                        brd_pkg::RESP_OKAY : brd_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= brd_pkg::CTRL_RESET;
    end else if (do_write && awaddr_reg == brd_pkg::CTRL_ADDR &&
                 wstrb_reg[0]) begin
      ctrl_reg <= wdata_reg[1:0];
    end
  end

  // Cause bits: set on a source's rising edge, write one to clear.
  // A set in the same cycle as its clear wins, so no event is lost.
  assign cause_set = {src_reg[7:0] & ~src_d_reg[7:0], 1'b0};
  assign cause_clr = (do_write && awaddr_reg == brd_pkg::CAUSE_ADDR) ?
                     (wdata_reg[8:0] & {wstrb_reg[1], {8{wstrb_reg[0]}}}) :
                     9'h000;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cause_reg <= brd_pkg::CAUSE_RESET;
    end else begin
      cause_reg <= (cause_reg & ~cause_clr) | cause_set;
    end
  end

  // Ready is a flop of its own and always the inverse of rvalid.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= brd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= brd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        brd_pkg::CTRL_ADDR:  s_axi_rdata <= {30'h0, ctrl_reg};
        brd_pkg::CAUSE_ADDR: s_axi_rdata <= {23'h0, cause_reg};
        brd_pkg::LEVEL_ADDR: s_axi_rdata <= {26'h0, vme_oe_reg,
                                             src_reg[brd_pkg::SRC_SYSCTL],
                                             ~rst_n_reg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= brd_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_reg <= 1'b1;
    end else begin
      por_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Cycles from the eighth held cycle to the release of a domain.
  localparam int HOLD_GAP = brd_pkg::HOLD_CYC - 6;

  a_switch_all: assert property (
    sw |=> !rst_n_reg[0] && !rst_n_reg[1] && !rst_n_reg[2])
    else $error("switch did not reset local domains");
  a_switch_vme: assert property (
    (sw && sysctl) |=> vme_oe_reg && !vme_sysreset_o)
    else $error("switch did not drive vme reset");
  a_wdog_vme: assert property (
    (wd && sysctl) |=> vme_oe_reg)
    else $error("watchdog did not drive vme reset");
  a_alt_isa: assert property (
    alt |=> !isa_reset_n_o && (vme_oe_reg || !$past(sysctl)))
    else $error("alternate request missed isa or vme");
  a_isaio_only: assert property (
    (isaio && !req[0] && cnt_reg[0] == 6'h00)
    |=> rst_n_reg[0] && !rst_n_reg[2])
    else $error("isa io request reached processor");
  a_vmein_hb: assert property (
    $rose(vin) |=> !rst_n_reg[1] && cause_reg[5])
    else $error("backplane reset missed host bridge");
  a_syssw_nocpu: assert property (
    (syssw && sysctl && !req[0] && cnt_reg[0] == 6'h00)
    |=> vme_oe_reg && rst_n_reg[0])
    else $error("system software reset wrong domains");
  a_local_novme: assert property (
    (loc && !req[3] && cnt_reg[3] == 6'h00)
    |=> !vme_oe_reg && !rst_n_reg[0])
    else $error("local reset wrong domains");
  a_por_hold: assert property (
    por_reg |-> (rst_n_reg == 4'h0) ##1 (rst_n_reg == 4'h0)[*8])
    else $error("power-on hold too short");
  a_hold_len: assert property (
    $fell(req[0]) |->
    (!rst_n_reg[0])[*8] ##[HOLD_GAP:HOLD_GAP] $rose(rst_n_reg[0]))
    else $error("processor reset released off time");

  c_switch: cover property (sw && sysctl ##1 vme_oe_reg);
  c_isaio: cover property (isaio && rst_n_reg[0]);
  c_cause_race: cover property (|(cause_set & cause_clr));
  c_bad_read: cover property (
    s_axi_rvalid && s_axi_rresp == brd_pkg::RESP_SLVERR);

endmodule : brd_reset_distribution
`default_nettype wire

// *** test/brd_backplane_model.sv ***
// Backplane model: the shared system reset line with its pull-up.
// Assumes the board pulls the line low only while its enable is high.
`default_nettype none
module brd_backplane_model (
  input  wire logic drive_oe_i,
  input  wire logic drive_val_i,
  input  wire logic remote_reset_i,
  output logic      line_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released line floats to its pull-up, never to the last driven level.
  assign line_n_o = !((drive_oe_i && !drive_val_i) || remote_reset_i);
endmodule : brd_backplane_model
`default_nettype wire

// *** test/tb_board_reset_distribution.sv ***
// Testbench for the board reset distribution block.
// Assumes one 25 MHz clock and a single AXI4-Lite master in this bench.
`default_nettype none
module tb_board_reset_distribution;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, ctl, bp_n, cpu_n, hb_n, isa_n, vo, voe;
  logic [7:0]  act;
  logic [3:0]  dom, m, e4, wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rs, c;
  int          bad_count, samples_checked, seed, s, p;
  // Domains hit by each source: bit0 cpu, bit1 bridge, bit2 ISA, bit3 VME.
  logic [3:0]  tbl [8] = '{4'hF, 4'h8, 4'hC, 4'h4, 4'h2, 4'h8, 4'h7, 4'h7};
  assign dom = {voe, isa_n, hb_n, cpu_n};
  brd_reset_distribution i_dut (
    .sys_clk_i(clk), .resetn_i(rst_n), .reset_switch_n_i(~act[0]),
    .watchdog_reset_n_i(~act[1]), .alternate_reset_request_i(act[2]),
    .isa_io_reset_request_i(act[3]), .vme_sysreset_n_i(bp_n),
    .vme_system_sw_reset_i(act[5]), .vme_local_sw_reset_i(act[6]),
    .vme_csr_reset_i(act[7]), .system_controller_i(ctl),
    .processor_unit_reset_n_o(cpu_n),
    .processor_host_bridge_reset_n_o(hb_n), .isa_reset_n_o(isa_n),
    .vme_sysreset_o(vo), .vme_sysreset_oe_o(voe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  brd_backplane_model i_bp (.drive_oe_i(voe), .drive_val_i(vo),
    .remote_reset_i(act[4]), .line_n_o(bp_n));
  always #20 clk = ~clk;
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One access at a time from one master keeps register ownership single.
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic por();
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    chk("reset domains", 32'h0, dom);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("post reset domains", {ctl, 3'h0}, dom);
    repeat (100) @(posedge clk);
    chk("idle domains", 32'h7, dom);
  endtask : por
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    bad_count++;
    wrap_up();
  end
  initial begin
    seed = 32'hB32F4DAC;
    {clk, rst_n, ctl, act, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    bad_count = 0;
    samples_checked = 0;
    @(posedge clk);
    por();
    axr(brd_pkg::CTRL_ADDR, rd, rs);
    chk("ctrl reset", brd_pkg::CTRL_RESET, rd);
    axr(brd_pkg::CAUSE_ADDR, rd, rs);
    chk("cause reset", brd_pkg::CAUSE_RESET, rd);
    axw(brd_pkg::CAUSE_ADDR, 32'h1FF, rs);
    for (p = 0; p < 2; p++) begin
      for (s = 0; s < 8; s++) begin
        c = 2'($random(seed));
        ctl <= 1'($random(seed));
        axw(brd_pkg::CTRL_ADDR, {30'h0, c}, rs);
        chk("ctrl write resp", brd_pkg::RESP_OKAY, rs);
        m = tbl[s];
        if (s == 1 && !c[0]) m = 4'h0;
        m[3] = m[3] & ctl & c[1];
        // Our own drive of the line comes back in and resets the bridge.
        if (m[3]) m[1] = 1'b1;
        e4 = {m[3], ~m[2:0]};
        act[s] <= 1'b1;
        repeat (8) @(posedge clk);
        chk("asserted", e4, dom);
        chk("vme data", {31'h0, ~m[3]}, vo);
        axr(brd_pkg::LEVEL_ADDR, rd, rs);
        chk("level", {26'h0, m[3], ctl, m}, rd);
        act[s] <= 1'b0;
        repeat (20) @(posedge clk);
        chk("held", e4, dom);
        repeat (80) @(posedge clk);
        chk("released", 32'h7, dom);
        axr(brd_pkg::CAUSE_ADDR, rd, rs);
        chk("cause", (32'h1 << (s + 1)) | (m[3] ? 32'h20 : 32'h0),
            rd);
        axw(brd_pkg::CAUSE_ADDR, 32'h1FF, rs);
      end
    end
    axr(12'hFFC, rd, rs);
    chk("unmapped read resp", brd_pkg::RESP_SLVERR, rs);
    chk("unmapped read data", 32'h0, rd);
    axw(12'hFFC, 32'hFFFFFFFF, rs);
    chk("unmapped write resp", brd_pkg::RESP_SLVERR, rs);
    ctl <= 1'b1;
    repeat (4) @(posedge clk);
    por();
    wrap_up();
  end
endmodule : tb_board_reset_distribution
`default_nettype wire
